// file: tb/bcc_host_model.sv
// Host processor model for the byte-wide register bus of the calendar clock
`timescale 1ns/1ns
module bcc_host_model (
	input wire logic clk,
	output logic [14:0] addr_in,
	output logic chip_en_n,
	output logic write_en_n,
	output logic out_en_n,
	output logic [7:0] dq_in,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe
);
	// Idle bus: deselected, strobes high
	initial begin
		addr_in = 15'h0000;
		chip_en_n = 1'b1;
		write_en_n = 1'b1;
		out_en_n = 1'b1;
		dq_in = 8'h00;
	end

	// One write; released data line shows the inverse so stale data never looks valid
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge clk);
		addr_in <= a;
		dq_in <= d;
		chip_en_n <= 1'b0;
		write_en_n <= 1'b0;
		@(posedge clk);
		chip_en_n <= 1'b1;
		write_en_n <= 1'b1;
		dq_in <= ~d;
		@(posedge clk);
		@(posedge clk);
	endtask : wr

	// One read; answer taken at the edge after it appears, request held until then
	task automatic rd(input logic [14:0] a, output logic [8:0] q);
		@(posedge clk);
		addr_in <= a;
		chip_en_n <= 1'b0;
		out_en_n <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		q = {dq_oe, dq_out};
		chip_en_n <= 1'b1;
		out_en_n <= 1'b1;
	endtask : rd
endmodule : bcc_host_model

// file: tb/tb.sv
// Self-checking testbench of the calendar clock
`timescale 1ns/1ns
module tb;
	import bcc_pkg::*;
	localparam int XT = 4;
	localparam logic [14:0] TADDR [0:7] = '{BCC_OFS_CENT, BCC_OFS_YEAR, BCC_OFS_MONTH,
		BCC_OFS_DATE, BCC_OFS_WDAY, BCC_OFS_HOUR, BCC_OFS_MIN, BCC_OFS_SEC};
	localparam logic [63:0] CASES [0:9] = '{
		64'h1999_1231_0723_5959, 64'h2000_0101_0100_0000,
		64'h2000_0228_0323_5959, 64'h2000_0229_0400_0000,
		64'h2100_0228_0223_5959, 64'h2100_0301_0300_0000,
		64'h2024_0229_0523_5959, 64'h2024_0301_0600_0000,
		64'h2025_0430_0723_5959, 64'h2025_0501_0100_0000};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic xtal_in = 1'b0;
	logic [14:0] addr_in;
	logic chip_en_n;
	logic write_en_n;
	logic out_en_n;
	logic [7:0] dq_in;
	logic [7:0] dq_out;
	logic dq_oe;
	int mismatches = 0;
	int checks = 0;
	int seed = 32'h0408aaf9;
	int cyc = 0;
	int s;
	logic [8:0] q;
	logic [63:0] t0;
	logic [63:0] t1;
	logic [7:0] v;

	bcc_clock #(.XTAL_PER_SEC(XT)) i_bcc_clock (.clk(clk), .reset_n(reset_n),
		.addr_in(addr_in), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
		.out_en_n(out_en_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.xtal_in(xtal_in));
	bcc_host_model i_bcc_host_model (.clk(clk), .addr_in(addr_in), .chip_en_n(chip_en_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe));

	// Clock and hang guard
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	function automatic logic [7:0] to_bcd(input int n);
		return 8'((n / 10) * 16 + n % 10);
	endfunction : to_bcd

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// One second of crystal edges, slow against clk so the synchroniser sees each
	task automatic tick();
		repeat (XT) begin
			repeat (3) @(posedge clk);
			xtal_in <= 1'b1;
			repeat (3) @(posedge clk);
			xtal_in <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask : tick

	task automatic rd_all(output logic [63:0] t);
		logic [8:0] r;
		for (int i = 0; i < 8; i++) begin
			i_bcc_host_model.rd(TADDR[i], r);
			t[63 - 8 * i -: 8] = r[7:0];
		end
	endtask : rd_all

	task automatic set_time(input logic [63:0] t);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h02);
		for (int i = 0; i < 8; i++)
			i_bcc_host_model.wr(TADDR[i], t[63 - 8 * i -: 8]);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h00);
	endtask : set_time

	// Set, freeze, let one second pass, then refresh and compare
	task automatic run_case(input logic [63:0] st, input logic [63:0] ex);
		logic [63:0] t;
		set_time(st);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h01);
		tick();
		rd_all(t);
		check("held time", t, st);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h00);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h01);
		rd_all(t);
		check("next time", t, ex);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h00);
	endtask : run_case

	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values, and a time write refused while the set bit is clear
		i_bcc_host_model.rd(BCC_OFS_TRIM, q);
		check("trim reset", q, {1'b1, BCC_TRIM_RST});
		i_bcc_host_model.wr(BCC_OFS_SEC, 8'h42);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h01);
		rd_all(t0);
		check("reset time", t0, BCC_TIME_RST);
		$display("test reset done");
		// Reserved bits, unmapped and outside addresses
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'hff);
		i_bcc_host_model.rd(BCC_OFS_STATUS, q);
		check("status mask", q, 9'h103);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h00);
		i_bcc_host_model.rd(15'h7ff2, q);
		check("unmapped", q, 9'h100);
		i_bcc_host_model.rd(15'h1234, q);
		check("outside page", q[8], 1'b0);
		// Oscillator off freezes time; trim keeps its stored bits
		v = 8'($random(seed)) | 8'h80;
		i_bcc_host_model.wr(BCC_OFS_TRIM, v);
		i_bcc_host_model.rd(BCC_OFS_TRIM, q);
		check("trim mask", q, {1'b1, v & BCC_MASK_TRIM});
		tick();
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h01);
		rd_all(t1);
		check("osc off", t1, t0);
		i_bcc_host_model.wr(BCC_OFS_STATUS, 8'h00);
		i_bcc_host_model.wr(BCC_OFS_TRIM, 8'h00);
		$display("test registers done");
		// Calendar corners
		for (int i = 0; i < 10; i += 2)
			run_case(CASES[i], CASES[i + 1]);
		$display("test corners done");
		// Random seconds within a minute
		repeat (6) begin
			s = int'($unsigned($random(seed)) % 59);
			run_case({56'h2001_0615_0310_20, to_bcd(s)}, {56'h2001_0615_0310_20, to_bcd(s + 1)});
		end
		$display("test random done");
		give_verdict();
	end
endmodule : tb

// file: verilog/bcc_clock.sv
// BCD calendar clock with byte-wide register access sampled on clk
//
// Behaviour
// - Time advances in one-second steps and the calendar stays valid over 9,999 years.
// - Weekday, date, leap years and century rollover are tracked from any set time.
// - Eight BCD time registers are set by host writes and returned by host reads.
// - Reserved bit positions of the clock registers read as zero and do nothing.
// - Freezing the readable registers never stops the running counters.
// - Writing one to the hold bit at 0x7FF0 copies the current time to holding registers.
// - The holding registers stay frozen until zero is written to the hold bit.
// - Within 20 ms of the hold bit going to zero all readable registers refresh together.
// - Writing one to the set bit lets the host write day, date and 24-hour BCD time.
// - The written time is kept as a base time and is the source of the current time.
// - Writing zero to the set bit loads the base time into the counters and resumes.
// - The oscillator-off bit is kept, zero lets the oscillator run, and it starts at zero.
`timescale 1ns/1ns
module bcc_clock #(
	parameter int XTAL_PER_SEC = bcc_pkg::BCC_XTAL_PER_SEC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [14:0] addr_in,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic xtal_in
);
	import bcc_pkg::*;

	bcc_time_t cnt_reg;
	bcc_time_t base_reg;
	bcc_time_t hold_reg;
	logic hold_flag_reg;
	logic set_flag_reg;
	logic [7:0] trim_reg;
	logic xtal_s1_reg;
	logic xtal_s2_reg;
	logic xtal_s3_reg;
	logic [14:0] div_reg;
	logic sec_tick_reg;
	logic wr_act_reg;
	logic [14:0] wr_addr_reg;
	logic [7:0] wr_data_reg;
	logic [7:0] dq_out_reg;
	logic dq_oe_reg;
	logic [7:0] rd_next;
	logic wr_act;
	logic commit;
	logic status_wr;
	logic set_load;
	logic time_wr;
	logic osc_off;

	// One BCD step with wrap; a value at or past the top wraps, so stray values recover
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] low);
		if (v >= top) begin
			return {1'b1, low};
		end else if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			return {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_step

	// Two-digit BCD to binary
	function automatic logic [6:0] bcd_bin(input logic [7:0] v);
		return ({3'b000, v[7:4]} * 7'd10) + {3'b000, v[3:0]};
	endfunction : bcd_bin

	// Last date of the current month, leap years by year and century
	function automatic logic [7:0] month_len(input bcc_time_t t);
		logic [6:0] y;
		logic [6:0] c;
		logic leap;
		y = bcd_bin(t.year);
		c = bcd_bin(t.cent);
		leap = (y[1:0] == 2'b00) && ((y != 7'd0) || (c[1:0] == 2'b00));
		case (t.month)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction : month_len

	// Full calendar carry chain for one second
	function automatic bcc_time_t next_second(input bcc_time_t t);
		bcc_time_t r;
		logic [8:0] s;
		r = t;
		s = bcd_step(t.sec, BCC_SEC_MAX, BCC_BCD_ZERO);
		r.sec = s[7:0];
		if (s[8]) begin
			s = bcd_step(t.min, BCC_MIN_MAX, BCC_BCD_ZERO);
			r.min = s[7:0];
			if (s[8]) begin
				s = bcd_step(t.hour, BCC_HOUR_MAX, BCC_BCD_ZERO);
				r.hour = s[7:0];
				if (s[8]) begin
					s = bcd_step(t.wday, BCC_WDAY_MAX, BCC_BCD_ONE);
					r.wday = s[7:0];
					s = bcd_step(t.date, month_len(t), BCC_BCD_ONE);
					r.date = s[7:0];
					if (s[8]) begin
						s = bcd_step(t.month, BCC_MONTH_MAX, BCC_BCD_ONE);
						r.month = s[7:0];
						if (s[8]) begin
							s = bcd_step(t.year, BCC_YEAR_MAX, BCC_BCD_ZERO);
							r.year = s[7:0];
							if (s[8]) begin
								// Century 00..99 gives the 9,999-year span
								s = bcd_step(t.cent, BCC_YEAR_MAX, BCC_BCD_ZERO);
								r.cent = s[7:0];
							end
						end
					end
				end
			end
		end
		return r;
	endfunction : next_second

	// True for an address of one of the eight time registers
	function automatic logic is_time_addr(input logic [14:0] a);
		return (a == BCC_OFS_CENT) || (a >= BCC_OFS_SEC);
	endfunction : is_time_addr

	// Bus decode; pins are taken as synchronous, a write lands when it ends
	assign wr_act = !chip_en_n && !write_en_n;
	assign commit = wr_act_reg && !wr_act;
	assign status_wr = commit && (wr_addr_reg == BCC_OFS_STATUS);
	assign set_load = status_wr && set_flag_reg && !wr_data_reg[BCC_SET_BIT];
	assign time_wr = commit && set_flag_reg && is_time_addr(wr_addr_reg);
	assign osc_off = trim_reg[BCC_OSC_OFF_BIT];

	// Track the write strobe and keep the last address and data it carried
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_act_reg <= 1'b0;
			wr_addr_reg <= 15'h0000;
			wr_data_reg <= 8'h00;
		end else begin
			wr_act_reg <= wr_act;
			if (wr_act) begin
				wr_addr_reg <= addr_in;
				wr_data_reg <= dq_in;
			end
		end
	end

	// Hold and set bits of the status/control register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hold_flag_reg <= BCC_STATUS_RST[BCC_HOLD_BIT];
			set_flag_reg <= BCC_STATUS_RST[BCC_SET_BIT];
		end else if (status_wr) begin
			hold_flag_reg <= wr_data_reg[BCC_HOLD_BIT];
			set_flag_reg <= wr_data_reg[BCC_SET_BIT];
		end
	end

	// Trim register, writable at any time; oscillator-off bit starts at zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			trim_reg <= BCC_TRIM_RST;
		end else if (commit && (wr_addr_reg == BCC_OFS_TRIM)) begin
			trim_reg <= wr_data_reg & BCC_MASK_TRIM;
		end
	end

	// Base time, written only while the set bit is one; reserved bits dropped
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			base_reg <= bcc_time_t'(BCC_TIME_RST);
		end else if (time_wr) begin
			case (wr_addr_reg)
				BCC_OFS_SEC: base_reg.sec <= wr_data_reg & BCC_MASK_SEC;
				BCC_OFS_MIN: base_reg.min <= wr_data_reg & BCC_MASK_MIN;
				BCC_OFS_HOUR: base_reg.hour <= wr_data_reg & BCC_MASK_HOUR;
				BCC_OFS_WDAY: base_reg.wday <= wr_data_reg & BCC_MASK_WDAY;
				BCC_OFS_DATE: base_reg.date <= wr_data_reg & BCC_MASK_DATE;
				BCC_OFS_MONTH: base_reg.month <= wr_data_reg & BCC_MASK_MONTH;
				BCC_OFS_YEAR: base_reg.year <= wr_data_reg & BCC_MASK_YEAR;
				BCC_OFS_CENT: base_reg.cent <= wr_data_reg & BCC_MASK_CENT;
				default: base_reg <= base_reg;
			endcase
		end
	end

	// Crystal input: two-stage synchroniser, third stage for edge detect
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xtal_s1_reg <= 1'b0;
			xtal_s2_reg <= 1'b0;
			xtal_s3_reg <= 1'b0;
		end else begin
			xtal_s1_reg <= xtal_in;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_s3_reg <= xtal_s2_reg;
		end
	end

	// Crystal divider; stalls while the oscillator is switched off
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_reg <= 15'h0000;
			sec_tick_reg <= 1'b0;
		end else begin
			sec_tick_reg <= 1'b0;
			if (xtal_s2_reg && !xtal_s3_reg && !osc_off) begin
				if (div_reg == 15'(XTAL_PER_SEC - 1)) begin
					div_reg <= 15'h0000;
					sec_tick_reg <= 1'b1;
				end else begin
					div_reg <= div_reg + 15'h0001;
				end
			end
		end
	end

	// Running counters; a load from the base time beats a tick in the same cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_reg <= bcc_time_t'(BCC_TIME_RST);
		end else if (set_load) begin
			cnt_reg <= base_reg;
		end else if (sec_tick_reg) begin
			cnt_reg <= next_second(cnt_reg);
		end
	end

	// Readable copy follows every cycle unless frozen, so release refreshes at once
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hold_reg <= bcc_time_t'(BCC_TIME_RST);
		end else if (!hold_flag_reg) begin
			hold_reg <= cnt_reg;
		end
	end

	// Read data mux over the register page
	always_comb begin
		case (addr_in)
			BCC_OFS_STATUS: rd_next = {6'b000000, set_flag_reg, hold_flag_reg};
			BCC_OFS_TRIM: rd_next = trim_reg;
			BCC_OFS_SEC: rd_next = hold_reg.sec & BCC_MASK_SEC;
			BCC_OFS_MIN: rd_next = hold_reg.min & BCC_MASK_MIN;
			BCC_OFS_HOUR: rd_next = hold_reg.hour & BCC_MASK_HOUR;
			BCC_OFS_WDAY: rd_next = hold_reg.wday & BCC_MASK_WDAY;
			BCC_OFS_DATE: rd_next = hold_reg.date & BCC_MASK_DATE;
			BCC_OFS_MONTH: rd_next = hold_reg.month & BCC_MASK_MONTH;
			BCC_OFS_YEAR: rd_next = hold_reg.year & BCC_MASK_YEAR;
			BCC_OFS_CENT: rd_next = hold_reg.cent & BCC_MASK_CENT;
			default: rd_next = 8'h00;
		endcase
	end

	// Drive the data pins one cycle after a read of the register page
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dq_out_reg <= 8'h00;
			dq_oe_reg <= 1'b0;
		end else begin
			dq_out_reg <= rd_next;
			dq_oe_reg <= !chip_en_n && !out_en_n && write_en_n && (addr_in[14:4] == BCC_PAGE_HI);
		end
	end

	assign dq_out = dq_out_reg;
	assign dq_oe = dq_oe_reg;

	// Checks on the counting and access paths
	sec_range_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cnt_reg.sec <= BCC_SEC_MAX) && (cnt_reg.hour <= BCC_HOUR_MAX))
		else $error("running time out of range");
	sec_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
		sec_tick_reg && !set_load && (cnt_reg.sec == BCC_SEC_MAX) |=>
		(cnt_reg.sec == BCC_BCD_ZERO) && (cnt_reg.min != $past(cnt_reg.min)))
		else $error("seconds did not carry into minutes");
	hold_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(hold_flag_reg) |-> hold_reg == $past(cnt_reg))
		else $error("hold did not capture current time");
	hold_frozen_a: assert property (@(posedge clk) disable iff (!reset_n)
		hold_flag_reg && $past(hold_flag_reg) |-> $stable(hold_reg))
		else $error("holding registers changed while frozen");
	hold_refresh_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(hold_flag_reg) |=> hold_reg == $past(cnt_reg))
		else $error("readable registers not refreshed after release");
	run_while_held_a: assert property (@(posedge clk) disable iff (!reset_n)
		sec_tick_reg && hold_flag_reg && !set_load |=> cnt_reg != $past(cnt_reg))
		else $error("counters stopped while frozen");
	ignore_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		commit && !set_flag_reg |=> $stable(base_reg))
		else $error("base time changed with set bit clear");
	base_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		set_load |=> cnt_reg == $past(base_reg))
		else $error("base time not loaded on set release");
	osc_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
		osc_off && $past(osc_off) |-> !sec_tick_reg && $stable(div_reg))
		else $error("divider ran with oscillator off");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		(hold_reg.hour[7:6] == 2'b00) && (hold_reg.wday[7:3] == 5'b00000))
		else $error("reserved clock bits not zero");
	read_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
		!chip_en_n && !out_en_n && write_en_n && (addr_in == BCC_OFS_SEC) |=>
		dq_oe && (dq_out == ($past(hold_reg.sec) & BCC_MASK_SEC)))
		else $error("seconds read not returned");

endmodule : bcc_clock

// file: verilog/bcc_pkg.sv
// Package: register map, field layout, reset values and timing of the calendar clock
package bcc_pkg;

	// Calendar time in BCD, one byte per field
	typedef struct packed {
		logic [7:0] cent;
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} bcc_time_t;

	// Register page: upper address bits of the clock register block
	localparam logic [10:0] BCC_PAGE_HI = 11'h7ff;

	// Byte addresses of the registers
	localparam logic [14:0] BCC_OFS_STATUS = 15'h7ff0;
	localparam logic [14:0] BCC_OFS_CENT = 15'h7ff1;
	localparam logic [14:0] BCC_OFS_TRIM = 15'h7ff8;
	localparam logic [14:0] BCC_OFS_SEC = 15'h7ff9;
	localparam logic [14:0] BCC_OFS_MIN = 15'h7ffa;
	localparam logic [14:0] BCC_OFS_HOUR = 15'h7ffb;
	localparam logic [14:0] BCC_OFS_WDAY = 15'h7ffc;
	localparam logic [14:0] BCC_OFS_DATE = 15'h7ffd;
	localparam logic [14:0] BCC_OFS_MONTH = 15'h7ffe;
	localparam logic [14:0] BCC_OFS_YEAR = 15'h7fff;

	// Bit positions in the status/control and trim registers
	localparam int BCC_HOLD_BIT = 0;
	localparam int BCC_SET_BIT = 1;
	localparam int BCC_OSC_OFF_BIT = 7;

	// Implemented bits of each register; all others read zero
	localparam logic [7:0] BCC_MASK_STATUS = 8'h03;
	localparam logic [7:0] BCC_MASK_TRIM = 8'hbf;
	localparam logic [7:0] BCC_MASK_SEC = 8'h7f;
	localparam logic [7:0] BCC_MASK_MIN = 8'h7f;
	localparam logic [7:0] BCC_MASK_HOUR = 8'h3f;
	localparam logic [7:0] BCC_MASK_WDAY = 8'h07;
	localparam logic [7:0] BCC_MASK_DATE = 8'h3f;
	localparam logic [7:0] BCC_MASK_MONTH = 8'h1f;
	localparam logic [7:0] BCC_MASK_YEAR = 8'hff;
	localparam logic [7:0] BCC_MASK_CENT = 8'hff;

	// Field limits in BCD
	localparam logic [7:0] BCC_SEC_MAX = 8'h59;
	localparam logic [7:0] BCC_MIN_MAX = 8'h59;
	localparam logic [7:0] BCC_HOUR_MAX = 8'h23;
	localparam logic [7:0] BCC_WDAY_MAX = 8'h07;
	localparam logic [7:0] BCC_MONTH_MAX = 8'h12;
	localparam logic [7:0] BCC_YEAR_MAX = 8'h99;
	localparam logic [7:0] BCC_BCD_ZERO = 8'h00;
	localparam logic [7:0] BCC_BCD_ONE = 8'h01;

	// Values after reset: 00-00-01-01, weekday 1, 00:00:00; oscillator running
	localparam logic [63:0] BCC_TIME_RST = 64'h0000_0101_0100_0000;
	localparam logic [7:0] BCC_TRIM_RST = 8'h00;
	localparam logic [7:0] BCC_STATUS_RST = 8'h00;

	// Crystal edges per second
	localparam int BCC_XTAL_PER_SEC = 32768;

	// Latest refresh after hold release, and its cycle count at 25 MHz
	localparam int BCC_CLK_HZ = 25000000;
	localparam int BCC_REFRESH_MS = 20;
	localparam int BCC_REFRESH_CYC = BCC_REFRESH_MS * (BCC_CLK_HZ / 1000);

endpackage : bcc_pkg
